// ===== hdl/mdt_pkg.sv
package mdt_pkg;
  // ----------------------------------------------------------------
  // target select patterns
  // ----------------------------------------------------------------
  localparam logic [1:0]  TGT_INPUT  = 2'b11;
  localparam logic [1:0]  TGT_OFFSET = 2'b10;
  localparam logic [1:0]  TGT_GAIN   = 2'b01;
  localparam logic [1:0]  TGT_SFR    = 2'b00;

  // ----------------------------------------------------------------
  // widths, reset values and code limits
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 14;
  localparam int          ADDR_W     = 6;
  localparam int          NUM_CH     = 40;
  localparam logic [13:0] INPUT_RST  = 14'h0000;
  localparam logic [13:0] OFFSET_RST = 14'h2000;
  localparam logic [13:0] GAIN_RST   = 14'h3FFE;
  localparam logic [13:0] TRIM_RST   = 14'h0000;
  localparam logic [13:0] CODE_MAX   = 14'h3FFF;
  localparam logic [16:0] OFFSET_MID = 17'h02000;
  localparam logic [14:0] GAIN_BIAS  = 15'h0002;

  // ----------------------------------------------------------------
  // special-function space and control word
  // ----------------------------------------------------------------
  localparam logic [5:0]  SFR_CTRL_WR  = 6'h0C;
  localparam logic [13:0] CTRL_RST     = 14'h2000;
  localparam int          CTRL_REF_SRC = 10;
  localparam int          CTRL_REF_LVL = 12;

  // ----------------------------------------------------------------
  // states of the calculation sequencer
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MDT_IDLE,
    MDT_CALC
  } mdt_state_t;
endpackage : mdt_pkg

// ===== hdl/mdt_trim_calc.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// one-cycle trim arithmetic with saturation
// ------------------------------------------------------------------
module mdt_trim_calc (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [13:0] code,
  input  wire logic [13:0] offset,
  input  wire logic [13:0] gain,
  output logic             done,
  output logic [13:0]      result
);
  logic [14:0] slope;
  logic [28:0] prod;
  logic [16:0] sum;
  logic [13:0] sat;
  logic [13:0] result_d;
  logic [13:0] result_q;
  logic        done_d;
  logic        done_q;

  // gain and offset applied; offset is offset binary around midscale
  always_comb begin
    slope = {1'b0, gain} + mdt_pkg::GAIN_BIAS;
    prod  = {14'h0000, slope} * {15'h0000, code};
    sum   = {2'b00, prod[28:14]} + {3'b000, offset}
            - mdt_pkg::OFFSET_MID;
    // clamp instead of wrapping so trims never fold the output over
    if (sum[16]) begin
      sat = 14'h0000;
    end else if (sum[15:14] != 2'b00) begin
      sat = mdt_pkg::CODE_MAX;
    end else begin
      sat = sum[13:0];
    end
    done_d   = start;
    result_d = start ? sat : result_q;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_q   <= 1'b0;
      result_q <= mdt_pkg::TRIM_RST;
    end else if (ce) begin
      done_q   <= done_d;
      result_q <= result_d;
    end
  end

  assign done   = done_q;
  assign result = result_q;
endmodule : mdt_trim_calc

// ===== hdl/mdt_datapath.sv
`timescale 1ns/1ps
// Operation
// - Target select 11 input, 10 offset, 01 gain, 00 special space.
// - Every written register takes a 14-bit word, bit 13 most significant.
// - Trimmed code is (gain+2)/2^14 times input plus offset minus 2^13.
// - Gain resets to 0x3FFE and stores bits 13..1 with bit 0 kept at zero.
// - Offset register is 14 bits wide and resets to 0x2000.
// - Offset is offset binary, 0x2000 meaning zero, one LSB per step.
// - Input code is straight binary, output fraction code/16384.
// - Each channel owns its offset and gain registers, apart from others.
// - Trimmed data waits in a first stage until the load moves it on.
// - Control bits choose internal or external reference and its level.
// - Busy is low during calculation; writes go on, converter updates wait.
// - A load seen while busy is remembered and done as soon as busy ends.
// - The six-bit channel address picks a channel with the target.
module mdt_datapath #(
  parameter int NUM_CH = mdt_pkg::NUM_CH
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        target_sel_hi,
  input  wire logic        target_sel_lo,
  input  wire logic [5:0]  channel_addr,
  input  wire logic [13:0] parallel_word_bits,
  input  wire logic        output_load_n,
  input  wire logic [5:0]  dac_sel,
  output logic             busy_n,
  output logic [13:0]      dac_code,
  output logic             ref_source_sel,
  output logic             ref_level_sel
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 63) begin : g_chk
    $error("NUM_CH must lie between 1 and 63");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [13:0]        input_q  [NUM_CH];
  logic [13:0]        input_d  [NUM_CH];
  logic [13:0]        offset_q [NUM_CH];
  logic [13:0]        offset_d [NUM_CH];
  logic [13:0]        gain_q   [NUM_CH];
  logic [13:0]        gain_d   [NUM_CH];
  logic [13:0]        trim_q   [NUM_CH];
  logic [13:0]        trim_d   [NUM_CH];
  logic [13:0]        dac_q    [NUM_CH];
  logic [13:0]        dac_d    [NUM_CH];
  logic [NUM_CH-1:0]  dirty_q;
  logic [NUM_CH-1:0]  dirty_d;
  logic [13:0]        ctrl_q;
  logic [13:0]        ctrl_d;
  logic               wr_prev_q;
  logic               ld_prev_q;
  logic               pend_q;
  logic               pend_d;
  logic [5:0]         calc_ch_q;
  logic [5:0]         calc_ch_d;
  logic [13:0]        code_q;
  logic [13:0]        code_d;
  mdt_pkg::mdt_state_t state_q;
  mdt_pkg::mdt_state_t state_d;

  logic        wr_hit;
  logic        ld_hit;
  logic [1:0]  tgt;
  logic        busy;
  logic        do_load;
  logic        calc_start;
  logic [5:0]  pick;
  logic        calc_done;
  logic [13:0] calc_res;

  // ----------------------------------------------------------------
  // strobes: write on rising wr_n with chip selected, load on falling
  // ----------------------------------------------------------------
  assign tgt    = {target_sel_hi, target_sel_lo};
  assign wr_hit = !wr_prev_q && wr_n && !cs_n;
  assign ld_hit = ld_prev_q && !output_load_n;
  // busy covers queued and running calculations
  assign busy   = (state_q != mdt_pkg::MDT_IDLE) || (|dirty_q);
  assign busy_n = !busy;
  assign do_load = !busy && (ld_hit || pend_q);

  // lowest dirty channel goes first; fixed priority is fine because
  // every dirty channel drains before a load may happen
  always_comb begin
    pick = 6'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (dirty_q[i]) begin
        pick = 6'(i);
      end
    end
  end

  assign calc_start = (state_q == mdt_pkg::MDT_IDLE) && (|dirty_q);

  // ----------------------------------------------------------------
  // register writes, dirty tracking and double buffer
  // ----------------------------------------------------------------
  always_comb begin
    input_d  = input_q;
    offset_d = offset_q;
    gain_d   = gain_q;
    trim_d   = trim_q;
    dac_d    = dac_q;
    dirty_d  = dirty_q;
    ctrl_d   = ctrl_q;
    // clear first so a write in the same cycle re-marks the channel
    if (calc_start) begin
      dirty_d[pick] = 1'b0;
    end
    if (wr_hit && tgt == mdt_pkg::TGT_SFR) begin
      if (channel_addr == mdt_pkg::SFR_CTRL_WR) begin
        ctrl_d = parallel_word_bits;
      end
    end else if (wr_hit && channel_addr < 6'(NUM_CH)) begin
      dirty_d[channel_addr] = 1'b1;
      case (tgt)
        mdt_pkg::TGT_INPUT: begin
          input_d[channel_addr] = parallel_word_bits;
        end
        mdt_pkg::TGT_OFFSET: begin
          offset_d[channel_addr] = parallel_word_bits;
        end
        mdt_pkg::TGT_GAIN: begin
          gain_d[channel_addr] = {parallel_word_bits[13:1],
                                  1'b0};
        end
        default: begin
          dirty_d[channel_addr] = dirty_q[channel_addr];
        end
      endcase
    end
    if (calc_done) begin
      trim_d[calc_ch_q] = calc_res;
    end
    if (do_load) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dac_d[i] = trim_q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        input_q[i]  <= mdt_pkg::INPUT_RST;
        offset_q[i] <= mdt_pkg::OFFSET_RST;
        gain_q[i]   <= mdt_pkg::GAIN_RST;
        trim_q[i]   <= mdt_pkg::TRIM_RST;
        dac_q[i]    <= mdt_pkg::TRIM_RST;
      end
      dirty_q <= '0;
      ctrl_q  <= mdt_pkg::CTRL_RST;
    end else if (ce) begin
      input_q  <= input_d;
      offset_q <= offset_d;
      gain_q   <= gain_d;
      trim_q   <= trim_d;
      dac_q    <= dac_d;
      dirty_q  <= dirty_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer, pending load and strobe history
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    calc_ch_d = calc_ch_q;
    // a new load request beats the clear of the stored one
    pend_d    = (pend_q && !do_load) || (ld_hit && busy);
    code_d    = code_q;
    case (state_q)
      mdt_pkg::MDT_IDLE: begin
        if (calc_start) begin
          calc_ch_d = pick;
          state_d   = mdt_pkg::MDT_CALC;
        end
      end
      mdt_pkg::MDT_CALC: begin
        if (calc_done) begin
          state_d = mdt_pkg::MDT_IDLE;
        end
      end
      default: begin
        state_d = mdt_pkg::MDT_IDLE;
      end
    endcase
    // out-of-range selects read as zero
    code_d = (dac_sel < 6'(NUM_CH)) ? dac_q[dac_sel] : 14'h0000;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= mdt_pkg::MDT_IDLE;
      calc_ch_q <= 6'h00;
      pend_q    <= 1'b0;
      wr_prev_q <= 1'b1;
      ld_prev_q <= 1'b1;
      code_q    <= 14'h0000;
    end else if (ce) begin
      state_q   <= state_d;
      calc_ch_q <= calc_ch_d;
      pend_q    <= pend_d;
      wr_prev_q <= wr_n;
      ld_prev_q <= output_load_n;
      code_q    <= code_d;
    end
  end

  // ----------------------------------------------------------------
  // arithmetic unit, fed with the picked channel's operands
  // ----------------------------------------------------------------
  mdt_trim_calc u_calc (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .ce     (ce),
    .start  (calc_start),
    .code   (input_q[pick]),
    .offset (offset_q[pick]),
    .gain   (gain_q[pick]),
    .done   (calc_done),
    .result (calc_res)
  );

  assign dac_code       = code_q;
  assign ref_source_sel = ctrl_q[mdt_pkg::CTRL_REF_SRC];
  assign ref_level_sel  = ctrl_q[mdt_pkg::CTRL_REF_LVL];
endmodule : mdt_datapath

// ===== tb/mdt_datapath_asserts.sv
`timescale 1ns/1ps
module mdt_datapath_asserts #(
  parameter int NUM_CH = 40
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        cs_n,
  input wire logic        wr_n,
  input wire logic        target_sel_hi,
  input wire logic        target_sel_lo,
  input wire logic [5:0]  channel_addr,
  input wire logic [13:0] parallel_word_bits,
  input wire logic        output_load_n,
  input wire logic [5:0]  dac_sel,
  input wire logic        busy_n,
  input wire logic [13:0] dac_code,
  input wire logic        ref_source_sel,
  input wire logic        ref_level_sel
);
  // ------------------------------------------------------------
  // write strobe edge tracking
  // ------------------------------------------------------------
  logic wr_prev_q, wr_prev_d, wr_take, chan, ctl;
  // history frozen with ce, like the block itself
  always_comb wr_prev_d = ce ? wr_n : wr_prev_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) wr_prev_q <= 1'b1;
    else wr_prev_q <= wr_prev_d;
  end
  // decoded kinds of taken write
  assign wr_take = ce & ~wr_prev_q & wr_n & ~cs_n;
  assign chan = {target_sel_hi, target_sel_lo} != mdt_pkg::TGT_SFR
                && channel_addr < NUM_CH;
  assign ctl = {target_sel_hi, target_sel_lo} == mdt_pkg::TGT_SFR
               && channel_addr == mdt_pkg::SFR_CTRL_WR;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_busy_start: assert property (
    wr_take && chan |=> !busy_n [*2]) else $error("busy not low");
  chk_busy_cause: assert property (
    $fell(busy_n) |-> $past(wr_take && chan)) else $error("busy cause");
  chk_busy_bound: assert property (
    !busy_n |-> ##[1:300] busy_n) else $error("busy stuck");
  chk_dac_hold: assert property (
    !busy_n ##1 $stable(dac_sel) |=> $stable(dac_code))
    else $error("dac moved while busy");
  chk_ref_cause: assert property (
    $changed({ref_source_sel, ref_level_sel}) |-> $past(wr_take && ctl))
    else $error("ref bits changed alone");
  chk_ref_value: assert property (
    wr_take && ctl |=> ref_source_sel == $past(parallel_word_bits[10])
    && ref_level_sel == $past(parallel_word_bits[12]))
    else $error("ref bits wrong");
  chk_sel_range: assert property (
    dac_sel >= NUM_CH |=> dac_code == 14'h0000) else $error("sel range");
  chk_ignored_wr: assert property (
    wr_take && !chan && busy_n |=> busy_n) else $error("ignored wr busy");
endmodule : mdt_datapath_asserts
bind mdt_datapath mdt_datapath_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .cs_n(cs_n), .wr_n(wr_n),
  .target_sel_hi(target_sel_hi), .target_sel_lo(target_sel_lo),
  .channel_addr(channel_addr), .parallel_word_bits(parallel_word_bits),
  .output_load_n(output_load_n), .dac_sel(dac_sel), .busy_n(busy_n),
  .dac_code(dac_code), .ref_source_sel(ref_source_sel),
  .ref_level_sel(ref_level_sel));

// ===== tb/mdt_host_model.sv
`timescale 1ns/1ps
module mdt_host_model (
  input  wire logic   mclk,
  output logic        cs_n,
  output logic        wr_n,
  output logic        target_sel_hi,
  output logic        target_sel_lo,
  output logic [5:0]  channel_addr,
  output logic [13:0] parallel_word_bits,
  output logic        output_load_n
);
  // idle bus: strobes high so reset release sees no edge
  initial begin
    {cs_n, wr_n, output_load_n} = 3'h7;
    {target_sel_hi, target_sel_lo} = 2'h0;
    channel_addr = 6'h00;
    parallel_word_bits = 14'h0000;
  end
  // one word: strobe low one cycle, taken on its rising edge
  task automatic write(input logic [1:0] tgt, input logic [5:0] adr,
                       input logic [13:0] dat);
    @(posedge mclk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    {target_sel_hi, target_sel_lo} <= tgt;
    channel_addr <= adr;
    parallel_word_bits <= dat;
    @(posedge mclk);
    wr_n <= 1'b1;
    @(posedge mclk);
    cs_n <= 1'b1;
    // released bus never shows the stale word
    parallel_word_bits <= ~dat;
  endtask : write
  // load strobe: one falling edge
  task automatic load();
    @(posedge mclk);
    output_load_n <= 1'b0;
    @(posedge mclk);
    output_load_n <= 1'b1;
  endtask : load
endmodule : mdt_host_model

// ===== tb/mdt_datapath_tb.sv
`timescale 1ns/1ps
`define MDT_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) \
  begin mismatches++; $display("ERROR %s exp %h got %h", nm, ex, got); \
  end end
module mdt_datapath_tb;
  logic        mclk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic        cs_n, wr_n, t_hi, t_lo, load_n, busy_n, r_src, r_lvl;
  logic [5:0]  addr, dac_sel = 6'h00;
  logic [13:0] data, dac_code, g[4], c[4], x[4];
  logic [5:0]  ch[4];
  int          mismatches = 0, checks_done = 0, cyc = 0;
  always #50 mclk = ~mclk;
  mdt_host_model u_host (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n),
    .target_sel_hi(t_hi), .target_sel_lo(t_lo), .channel_addr(addr),
    .parallel_word_bits(data), .output_load_n(load_n));
  mdt_datapath #(.NUM_CH(40)) u_dut (.mclk(mclk), .rst_b(rst_b),
    .ce(ce), .cs_n(cs_n), .wr_n(wr_n), .target_sel_hi(t_hi),
    .target_sel_lo(t_lo), .channel_addr(addr), .parallel_word_bits(data),
    .output_load_n(load_n), .dac_sel(dac_sel), .busy_n(busy_n),
    .dac_code(dac_code), .ref_source_sel(r_src), .ref_level_sel(r_lvl));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // reference trim with clamping; gain bit 0 never counts
  function automatic logic [13:0] trim(logic [13:0] gg, cc, xx);
    int v;
    v = ((((gg & 14'h3FFE) + 2) * xx) >> 14) + cc - 8192;
    return v < 0 ? 14'h0000 : v > 16383 ? 14'h3FFF : v[13:0];
  endfunction : trim
  task automatic rd(input logic [5:0] s, input logic [13:0] ex);
    @(posedge mclk);
    dac_sel <= s;
    @(posedge mclk);
    @(negedge mclk);
    `MDT_CHK("dac_code", ex, dac_code)
  endtask : rd
  task automatic wait_idle();
    // step off the edge first so a just-taken write is already visible
    @(negedge mclk);
    for (int n = 0; n < 300 && busy_n !== 1'b1; n++) @(negedge mclk);
    `MDT_CHK("busy_n", 1'b1, busy_n)
  endtask : wait_idle
  task automatic close_out();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // hang guard, far above the hundred or so cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    ch = '{6'd3, 6'd5, 6'd39, 6'd0};
    g = '{14'h3FFE, 14'h2001, 14'h3FFE, 14'h3FFE};
    c = '{14'h2000, 14'h2005, 14'h3FFF, 14'h0000};
    x = '{14'h1234, 14'h3FFF, 14'h3FFF, 14'h0001};
    repeat (3) @(posedge mclk);
    `MDT_CHK("rst busy_n", 1'b1, busy_n)
    `MDT_CHK("rst ref", 2'b00, {r_src, r_lvl})
    rst_b <= 1'b1;
    rd(6'd3, 14'h0000);
    // input, offset and gain targets, one table row per channel; row 0 writes input only
    for (int i = 0; i < 4; i++) begin
      if (i != 0) u_host.write(mdt_pkg::TGT_GAIN, ch[i], g[i]);
      if (i != 0) u_host.write(mdt_pkg::TGT_OFFSET, ch[i], c[i]);
      u_host.write(mdt_pkg::TGT_INPUT, ch[i], x[i]);
    end
    wait_idle();
    rd(6'd3, 14'h0000);
    u_host.load();
    for (int i = 0; i < 4; i++) rd(ch[i], trim(g[i], c[i], x[i]));
    // load during calculation is held until busy ends
    rd(6'd3, 14'h1234);
    u_host.write(mdt_pkg::TGT_INPUT, 6'd3, 14'h0ABC);
    @(negedge mclk);
    `MDT_CHK("busy_n", 1'b0, busy_n)
    u_host.load();
    @(negedge mclk);
    `MDT_CHK("held dac", 14'h1234, dac_code)
    wait_idle();
    rd(6'd3, 14'h0ABC);
    // clock enable low freezes the block: write and load are both lost
    @(posedge mclk) ce <= 1'b0;
    u_host.write(mdt_pkg::TGT_INPUT, 6'd3, 14'h0123);
    u_host.load();
    @(posedge mclk) ce <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    `MDT_CHK("frozen busy_n", 1'b1, busy_n)
    rd(6'd3, 14'h0ABC);
    // control word, then an unused special address
    u_host.write(mdt_pkg::TGT_SFR, mdt_pkg::SFR_CTRL_WR, 14'h3400);
    @(negedge mclk);
    `MDT_CHK("ref", 2'b11, {r_src, r_lvl})
    u_host.write(mdt_pkg::TGT_SFR, 6'h01, 14'h0000);
    u_host.write(mdt_pkg::TGT_SFR, mdt_pkg::SFR_CTRL_WR, 14'h0400);
    @(negedge mclk);
    `MDT_CHK("ref", 2'b10, {r_src, r_lvl})
    // channel beyond the last one is ignored
    u_host.write(mdt_pkg::TGT_INPUT, 6'd40, 14'h1111);
    @(negedge mclk);
    `MDT_CHK("busy_n", 1'b1, busy_n)
    rd(6'd40, 14'h0000);
    close_out();
  end
endmodule : mdt_datapath_tb
